/* hw/qsswd_chan.sv */
/*
 * One supply-monitor channel: immediate assertion, delayed release.
 * Assumes a synchronised release condition from the same clock.
 */
`timescale 1ns/1ps
module qsswd_chan
    import qsswd_pkg::*;
#(
    parameter qsswd_cnt_t OPEN_CYC = QSSWD_DLY_OPEN_CYC,
    parameter qsswd_cnt_t PULLUP_CYC = QSSWD_DLY_PULLUP_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic release_ok,
    input wire logic [1:0] dly_mode,
    input wire qsswd_cnt_t prog_cyc,
    output logic reset_out_n
);

    qsswd_st_t st_q;
    qsswd_cnt_t cnt_q;
    qsswd_cnt_t tgt;
    logic out_q;

    // Delay length from the selected mode, never below one cycle
    always_comb begin
        case (qsswd_dly_t'(dly_mode))
            QSSWD_DLY_PULLUP: tgt = PULLUP_CYC;
            QSSWD_DLY_CAP: tgt = prog_cyc;
            default: tgt = OPEN_CYC;
        endcase
        if (tgt == '0) begin
            tgt = qsswd_cnt_t'(1);
        end
    end

    // Assert at once, count the release delay, restart on every assertion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= QSSWD_ST_ASSERTED;
            cnt_q <= '0;
            out_q <= 1'b0;
        end else if (!release_ok) begin
            st_q <= QSSWD_ST_ASSERTED;
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            case (st_q)
                QSSWD_ST_ASSERTED: begin
                    if (cnt_q >= tgt - qsswd_cnt_t'(1)) begin
                        st_q <= QSSWD_ST_RELEASED;
                        out_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + qsswd_cnt_t'(1);
                    end
                end
                QSSWD_ST_RELEASED: out_q <= 1'b1;
                default: st_q <= QSSWD_ST_ASSERTED;
            endcase
        end
    end

    assign reset_out_n = out_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_drop;
        out_q && !release_ok;
    endsequence

    AST_REL_AFTER_DELAY: assert property ($rose(out_q) |-> $past(release_ok) &&
        ($past(cnt_q) >= $past(tgt) - qsswd_cnt_t'(1)))
        else $error("channel released before its delay");
    AST_ASSERT_NOW: assert property (s_drop |=> !out_q)
        else $error("channel assertion was delayed");
    AST_RESTART: assert property (!release_ok |=> cnt_q == '0 ##0 !out_q)
        else $error("delay count not restarted");

endmodule

/* hw/qsswd_pkg.sv */
/*
 * Shared constants, types and register map for the quad supply
 * supervisor with watchdog.
 * Assumes a single 100 MHz clock and an AXI4-Lite register master.
 */
// Function
// - After the release condition holds, keep reset asserted for the delay, then release
// - Any assert condition asserts the channel reset at once, without delay
// - Manual reset low holds the channel-1 reset asserted while low
// - Channel 1 releases only with manual reset high and monitor 1 above threshold
// - Channels 1-3 and window low assert on undervoltage, release after delay
// - Channel 4 releases only with low above and high below threshold
// - All channels follow their comparator result in the same manner
// - Watchdog counts only while channel 1 is released, no timeout otherwise
// - Every kick edge clears the watchdog count and restarts it
// - No kick edge within the period while released raises the watchdog fault
// - The watchdog fault is latched regardless of later kick edges
// - Kick toggling never clears a latched fault, in either channel-1 state
// - Only a channel-1 reset assertion clears the latched fault
// - Each channel delay is selectable: 300 ms, 20 ms or programmable
// - Programmable delay restarts on every assertion, ramp runs from release condition
// - Watchdog period is 600 ms, counted from release or last kick edge
package qsswd_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int QSSWD_CLK_HZ = 100_000_000;
    localparam int QSSWD_CYC_PER_MS = QSSWD_CLK_HZ / 1000;
    localparam int QSSWD_DLY_OPEN_MS = 20;
    localparam int QSSWD_DLY_PULLUP_MS = 300;
    localparam int QSSWD_WDT_MS = 600;
    localparam int QSSWD_CNT_W = 32;
    typedef logic [QSSWD_CNT_W-1:0] qsswd_cnt_t;
    localparam qsswd_cnt_t QSSWD_DLY_OPEN_CYC = qsswd_cnt_t'(QSSWD_DLY_OPEN_MS * QSSWD_CYC_PER_MS);
    localparam qsswd_cnt_t QSSWD_DLY_PULLUP_CYC = qsswd_cnt_t'(QSSWD_DLY_PULLUP_MS * QSSWD_CYC_PER_MS);
    localparam qsswd_cnt_t QSSWD_WDT_CYC = qsswd_cnt_t'(QSSWD_WDT_MS * QSSWD_CYC_PER_MS);

    // ----------------------------------------
    // Modes and states
    // ----------------------------------------
    typedef enum logic [1:0] {
        QSSWD_DLY_OPEN = 2'b00,
        QSSWD_DLY_PULLUP = 2'b01,
        QSSWD_DLY_CAP = 2'b10
    } qsswd_dly_t;
    typedef enum logic {
        QSSWD_ST_ASSERTED = 1'b0,
        QSSWD_ST_RELEASED = 1'b1
    } qsswd_st_t;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int QSSWD_ADDR_W = 8;
    localparam int QSSWD_NCH = 4;
    localparam int QSSWD_IRQ_W = 5;
    localparam int QSSWD_MODE_W = 2;
    localparam int QSSWD_NPIN = 7;
    localparam logic [7:0] QSSWD_REG_CTRL = 8'h00;
    localparam logic [7:0] QSSWD_REG_PROG = 8'h04;
    localparam logic [7:0] QSSWD_REG_STATUS = 8'h08;
    localparam logic [7:0] QSSWD_REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] QSSWD_REG_IRQ_CLR = 8'h10;
    localparam logic [7:0] QSSWD_REG_IRQ_EN = 8'h14;
    localparam logic [31:0] QSSWD_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] QSSWD_PROG_RST = 32'h0001_0000;
    localparam logic [1:0] QSSWD_RESP_OKAY = 2'b00;
    localparam logic [1:0] QSSWD_RESP_SLVERR = 2'b10;

endpackage

/* hw/qsswd_sync.sv */
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes an asynchronous level input; output resets low.
 */
`timescale 1ns/1ps
module qsswd_sync
    import qsswd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic din,
    output logic dout
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic dout_q;

    // Shift chain; a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout_q <= s3_q;
            end
        end
    end

    assign dout = dout_q;

endmodule

/* hw/qsswd_top.sv */
/*
 * Quad supply supervisor with watchdog: four reset channels, a
 * watchdog tied to channel 1, interrupts and an AXI4-Lite slave.
 * Assumes comparator flags and pins arrive asynchronously.
 */
`timescale 1ns/1ps
module qsswd_top
    import qsswd_pkg::*;
#(
    parameter qsswd_cnt_t DLY_OPEN_CYC = QSSWD_DLY_OPEN_CYC,
    parameter qsswd_cnt_t DLY_PULLUP_CYC = QSSWD_DLY_PULLUP_CYC,
    parameter qsswd_cnt_t WDT_CYC = QSSWD_WDT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [QSSWD_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [QSSWD_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic monitor_in_1,
    input wire logic monitor_in_2,
    input wire logic monitor_in_3,
    input wire logic window_low_monitor_in,
    input wire logic window_high_monitor_in,
    input wire logic manual_reset_in_n,
    input wire logic watchdog_kick_in,
    output logic primary_reset_out_n,
    output logic [1:0] channel_reset_out_n,
    output logic window_reset_out_n,
    output logic watchdog_fault_out_n,
    output logic irq
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // True for an address that maps to a register
    function automatic logic addr_ok(input logic [QSSWD_ADDR_W-1:0] a);
        case (a)
            QSSWD_REG_CTRL, QSSWD_REG_PROG, QSSWD_REG_STATUS,
            QSSWD_REG_IRQ_STAT, QSSWD_REG_IRQ_CLR, QSSWD_REG_IRQ_EN: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        merge = r;
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [QSSWD_NPIN-1:0] pin_raw;
    logic [QSSWD_NPIN-1:0] pin_s;
    logic m1_s, m2_s, m3_s, wl_s, wh_s, mr_s, kick_s;

    assign pin_raw = {watchdog_kick_in, manual_reset_in_n, window_high_monitor_in,
        window_low_monitor_in, monitor_in_3, monitor_in_2, monitor_in_1};
    assign {kick_s, mr_s, wh_s, wl_s, m3_s, m2_s, m1_s} = pin_s;

    // Every pin passes the three-stage filter
    for (genvar p = 0; p < QSSWD_NPIN; p++) begin : g_sync
        qsswd_sync u_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .din(pin_raw[p]),
            .dout(pin_s[p])
        );
    end

    // ----------------------------------------
    // Reset channels
    // ----------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] prog_q;
    logic [QSSWD_NCH-1:0] rel_ok;
    logic [QSSWD_NCH-1:0] ch_rst_n;

    // Release conditions per channel
    assign rel_ok[0] = mr_s & m1_s;
    assign rel_ok[1] = m2_s;
    assign rel_ok[2] = m3_s;
    assign rel_ok[3] = wl_s & ~wh_s;

    // Identical channel logic for all four monitors
    for (genvar c = 0; c < QSSWD_NCH; c++) begin : g_chan
        qsswd_chan #(
            .OPEN_CYC(DLY_OPEN_CYC),
            .PULLUP_CYC(DLY_PULLUP_CYC)
        ) u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .release_ok(rel_ok[c]),
            .dly_mode(ctrl_q[QSSWD_MODE_W*c +: QSSWD_MODE_W]),
            .prog_cyc(prog_q),
            .reset_out_n(ch_rst_n[c])
        );
    end

    assign primary_reset_out_n = ch_rst_n[0];
    assign channel_reset_out_n = ch_rst_n[2:1];
    assign window_reset_out_n = ch_rst_n[3];

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    logic kick_prev_q;
    logic kick_edge;
    qsswd_cnt_t wdt_cnt_q;
    logic wdt_fault_n_q;

    assign kick_edge = kick_s ^ kick_prev_q;

    // Edge detector on the synchronised kick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kick_prev_q <= 1'b0;
        end else begin
            kick_prev_q <= kick_s;
        end
    end

    // Up-count runs only while channel 1 is released and no fault is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_cnt_q <= '0;
        end else if (!ch_rst_n[0] || !wdt_fault_n_q) begin
            wdt_cnt_q <= '0;
        end else if (kick_edge) begin
            wdt_cnt_q <= '0;
        end else begin
            wdt_cnt_q <= wdt_cnt_q + qsswd_cnt_t'(1);
        end
    end

    // Latched fault, cleared only by a channel-1 assertion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_fault_n_q <= 1'b1;
        end else if (!ch_rst_n[0]) begin
            wdt_fault_n_q <= 1'b1;
        end else if (!kick_edge && wdt_cnt_q >= WDT_CYC - qsswd_cnt_t'(1)) begin
            wdt_fault_n_q <= 1'b0;
        end
    end

    assign watchdog_fault_out_n = wdt_fault_n_q;

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    logic [QSSWD_NCH-1:0] ch_prev_q;
    logic wdo_prev_q;
    logic [QSSWD_IRQ_W-1:0] irq_ev;
    logic [QSSWD_IRQ_W-1:0] irq_stat_q;
    logic [QSSWD_IRQ_W-1:0] irq_en_q;
    logic [QSSWD_IRQ_W-1:0] irq_clr;
    logic irq_q;

    // Events: a channel asserting, the watchdog fault appearing
    assign irq_ev = {wdo_prev_q & ~wdt_fault_n_q, ch_prev_q & ~ch_rst_n};

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_prev_q <= '0;
            wdo_prev_q <= 1'b1;
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ch_prev_q <= ch_rst_n;
            wdo_prev_q <= wdt_fault_n_q;
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    assign irq = irq_q;

    // ----------------------------------------
    // AXI4-Lite write side
    // ----------------------------------------
    logic awready_q, wready_q, bvalid_q;
    logic [1:0] bresp_q;
    logic [QSSWD_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;

    // Both halves held and no response pending
    assign wr_go = !awready_q && !wready_q && !bvalid_q;

    // Address and data taken in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= QSSWD_RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            if (awvalid && awready_q) begin
                aw_addr_q <= awaddr;
                awready_q <= 1'b0;
            end
            if (wvalid && wready_q) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                wready_q <= 1'b0;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= addr_ok(aw_addr_q) ? QSSWD_RESP_OKAY : QSSWD_RESP_SLVERR;
            end
            if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Clear pulse from the write-only clear register
    assign irq_clr = (wr_go && aw_addr_q == QSSWD_REG_IRQ_CLR && w_strb_q[0]) ?
        w_data_q[QSSWD_IRQ_W-1:0] : '0;

    // Writable configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= QSSWD_CTRL_RST;
            prog_q <= QSSWD_PROG_RST;
            irq_en_q <= '0;
        end else if (wr_go) begin
            case (aw_addr_q)
                QSSWD_REG_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
                QSSWD_REG_PROG: prog_q <= merge(prog_q, w_data_q, w_strb_q);
                QSSWD_REG_IRQ_EN: begin
                    irq_en_q <= w_strb_q[0] ? w_data_q[QSSWD_IRQ_W-1:0] : irq_en_q;
                end
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // ----------------------------------------
    // AXI4-Lite read side
    // ----------------------------------------
    logic arready_q, rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;

    // Read data selection; unmapped and write-only read as zero
    always_comb begin
        case (araddr)
            QSSWD_REG_CTRL: rd_mux = ctrl_q;
            QSSWD_REG_PROG: rd_mux = prog_q;
            QSSWD_REG_STATUS: rd_mux = {27'h0, ~wdt_fault_n_q, ~ch_rst_n};
            QSSWD_REG_IRQ_STAT: rd_mux = {27'h0, irq_stat_q};
            QSSWD_REG_IRQ_EN: rd_mux = {27'h0, irq_en_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // One read at a time, answered the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= QSSWD_RESP_OKAY;
            rdata_q <= '0;
        end else begin
            if (arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= addr_ok(araddr) ? QSSWD_RESP_OKAY : QSSWD_RESP_SLVERR;
            end
            if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_expire;
        ch_rst_n[0] && wdt_fault_n_q && !kick_edge && wdt_cnt_q == WDT_CYC - qsswd_cnt_t'(1);
    endsequence

    AST_MR_HOLDS: assert property (!mr_s |=> !primary_reset_out_n)
        else $error("manual reset did not hold channel 1");
    AST_CH1_COND: assert property ($rose(primary_reset_out_n) |-> $past(mr_s && m1_s))
        else $error("channel 1 released without both conditions");
    AST_UV_ASSERT: assert property (!m2_s |=> !channel_reset_out_n[0])
        else $error("undervoltage did not assert channel 2");
    AST_WINDOW: assert property ((!wl_s || wh_s) |=> !window_reset_out_n)
        else $error("window channel released out of window");
    AST_WDT_IDLE: assert property (!primary_reset_out_n |=> wdt_cnt_q == '0 && watchdog_fault_out_n)
        else $error("watchdog active while channel 1 asserted");
    AST_KICK_RESTART: assert property (kick_edge |=> wdt_cnt_q == '0)
        else $error("kick edge did not restart watchdog");
    AST_TIMEOUT: assert property (s_expire |=> !watchdog_fault_out_n)
        else $error("watchdog timeout not flagged");
    AST_FAULT_LATCH: assert property (!watchdog_fault_out_n && primary_reset_out_n |=>
        !watchdog_fault_out_n)
        else $error("latched fault cleared without channel-1 reset");
    AST_FAULT_CLEAR: assert property ($fell(primary_reset_out_n) |=> watchdog_fault_out_n)
        else $error("channel-1 reset did not clear fault");

endmodule

/* tb/qsswd_cpu_model.sv */
/*
 * Processor model: takes the primary reset and toggles the kick line.
 * Assumes the bench clock and a period well under the watchdog timeout.
 */
`timescale 1ns/1ps
module qsswd_cpu_model
    import qsswd_pkg::*;
(
    input wire logic aclk,
    input wire logic primary_reset_out_n,
    input wire logic kick_en,
    input wire logic [7:0] kick_per,
    output logic watchdog_kick_in
);
    logic [7:0] cnt_q = 8'h00;
    initial watchdog_kick_in = 1'b0;
    // Kick once a period while running; silent while held in reset
    always @(posedge aclk) begin
        if (!primary_reset_out_n || !kick_en) begin
            cnt_q <= 8'h00;
        end else if (cnt_q >= kick_per) begin
            cnt_q <= 8'h00;
            watchdog_kick_in <= ~watchdog_kick_in;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

/* tb/test_quad_supply_supervisor_watchdog.sv */
/*
 * Self-checking bench for the supervisor: channels, watchdog, registers.
 * Assumes short delay parameters and a kicking processor model.
 */
`timescale 1ns/1ps
module test_quad_supply_supervisor_watchdog;
    import qsswd_pkg::*;
    localparam qsswd_cnt_t OPN = 20;
    localparam qsswd_cnt_t PUL = 40;
    localparam qsswd_cnt_t WDT = 50;
    typedef struct {logic [1:0] kind; logic [33:0] exp; logic [33:0] msk; string lbl;} qsswd_note_t;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, channel_reset_out_n;
    logic [31:0] rdata;
    logic monitor_in_1 = 1'b1, monitor_in_2 = 1'b1, monitor_in_3 = 1'b1;
    logic window_low_monitor_in = 1'b1, window_high_monitor_in = 1'b0, manual_reset_in_n = 1'b1;
    logic watchdog_kick_in, primary_reset_out_n, window_reset_out_n, watchdog_fault_out_n;
    logic kick_en = 1'b1, pin_ev = 1'b0;
    logic [7:0] kick_per = 8'h19;
    qsswd_note_t notes[$];
    int n_fail = 0;
    int checks_done = 0;

    qsswd_top #(.DLY_OPEN_CYC(OPN), .DLY_PULLUP_CYC(PUL), .WDT_CYC(WDT)) qsswd_top_i (.aclk, .aresetn,
        .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .monitor_in_1, .monitor_in_2,
        .monitor_in_3, .window_low_monitor_in, .window_high_monitor_in, .manual_reset_in_n, .watchdog_kick_in,
        .primary_reset_out_n, .channel_reset_out_n, .window_reset_out_n, .watchdog_fault_out_n, .irq);
    qsswd_cpu_model qsswd_cpu_model_i (.aclk, .primary_reset_out_n, .kick_en, .kick_per, .watchdog_kick_in);

    always #5 aclk = ~aclk;

    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    // Oldest note is compared against each answer or pin sample
    always @(posedge aclk) begin
        logic [1:0] k;
        logic [33:0] seen;
        qsswd_note_t n;
        k = (rvalid && rready) ? 2'd0 : (bvalid && bready) ? 2'd1 : pin_ev ? 2'd2 : 2'd3;
        seen = (k == 2'd0) ? {rresp, rdata} : (k == 2'd1) ? {bresp, 32'h0} : {28'h0, irq,
            watchdog_fault_out_n, window_reset_out_n, channel_reset_out_n, primary_reset_out_n};
        if (k != 2'd3 && notes.size() > 0) begin
            n = notes.pop_front();
            checks_done++;
            if (n.kind != k || (seen & n.msk) !== (n.exp & n.msk)) begin
                n_fail++;
                $display("ERROR %s expected %h seen %h", n.lbl, n.exp & n.msk, seen & n.msk);
            end
        end
    end

    // ----------------------------------------
    // Driver tasks
    // ----------------------------------------
    task automatic note(input logic [1:0] k, input logic [33:0] e, input logic [33:0] m, input string l);
        notes.push_back('{k, e, m, l});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write with address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        note(2'd1, {r, 32'h0}, {2'h3, 32'h0}, "bresp");
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
            begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
        join
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r, input logic [31:0] m);
        note(2'd0, {r, e}, {2'h3, m}, "rdata");
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Pin vector: irq, fault, window, channel 3, channel 2, primary
    task automatic pins(input logic [5:0] e, input logic [5:0] m);
        note(2'd2, {28'h0, e}, {28'h0, m}, "pins");
        pin_ev <= 1'b1;
        @(posedge aclk);
        pin_ev <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        int dly;
        int prog;
        void'($urandom(32'h7C51));
        kick_per <= 8'(25 + $urandom % 14);
        prog = 10 + $urandom % 30;
        cyc(10);
        aresetn <= 1'b1;
        pins(6'h10, 6'h3F);
        rd(QSSWD_REG_CTRL, QSSWD_CTRL_RST, QSSWD_RESP_OKAY, 32'hFFFF_FFFF);
        rd(QSSWD_REG_PROG, QSSWD_PROG_RST, QSSWD_RESP_OKAY, 32'hFFFF_FFFF);
        rd(QSSWD_REG_IRQ_EN, 32'h0, QSSWD_RESP_OKAY, 32'hFFFF_FFFF);
        rd(8'h18, 32'h0, QSSWD_RESP_SLVERR, 32'hFFFF_FFFF);
        wr(8'h18, 32'h1, QSSWD_RESP_SLVERR);
        $display("test registers done");
        wr(QSSWD_REG_PROG, 32'(prog), QSSWD_RESP_OKAY);
        // Every delay mode on channels 2 and 3 together
        for (int md = 0; md < 4; md++) begin
            dly = (md == 1) ? int'(PUL) : (md == 2) ? prog : int'(OPN);
            wr(QSSWD_REG_CTRL, 32'(md * 20), QSSWD_RESP_OKAY);
            monitor_in_2 <= 1'b0;
            monitor_in_3 <= 1'b0;
            cyc(8);
            pins(6'h00, 6'h06);
            monitor_in_2 <= 1'b1;
            monitor_in_3 <= 1'b1;
            cyc(dly - 2);
            pins(6'h00, 6'h06);
            cyc(8);
            pins(6'h06, 6'h06);
        end
        $display("test delays done");
        manual_reset_in_n <= 1'b0;
        cyc(8);
        pins(6'h00, 6'h01);
        manual_reset_in_n <= 1'b1;
        monitor_in_1 <= 1'b0;
        cyc(OPN + 10);
        pins(6'h00, 6'h01);
        monitor_in_1 <= 1'b1;
        cyc(OPN + 10);
        pins(6'h01, 6'h01);
        // Window channel over all four flag combinations
        for (int c = 0; c < 4; c++) begin
            window_low_monitor_in <= c[0];
            window_high_monitor_in <= c[1];
            cyc(OPN + 12);
            pins({2'b00, c == 1, 3'b000}, 6'h08);
        end
        window_low_monitor_in <= 1'b1;
        window_high_monitor_in <= 1'b0;
        $display("test channels done");
        cyc(4 * WDT);
        pins(6'h10, 6'h10);
        wr(QSSWD_REG_IRQ_EN, 32'h10, QSSWD_RESP_OKAY);
        wr(QSSWD_REG_IRQ_CLR, 32'h1F, QSSWD_RESP_OKAY);
        kick_en <= 1'b0;
        manual_reset_in_n <= 1'b0;
        cyc(2 * WDT);
        pins(6'h10, 6'h11);
        manual_reset_in_n <= 1'b1;
        cyc(OPN + WDT - 4);
        pins(6'h11, 6'h11);
        cyc(12);
        pins(6'h21, 6'h31);
        rd(QSSWD_REG_STATUS, 32'h10, QSSWD_RESP_OKAY, 32'h10);
        kick_en <= 1'b1;
        cyc(3 * WDT);
        pins(6'h21, 6'h31);
        wr(QSSWD_REG_IRQ_EN, 32'h0, QSSWD_RESP_OKAY);
        pins(6'h00, 6'h30);
        wr(QSSWD_REG_IRQ_CLR, 32'h10, QSSWD_RESP_OKAY);
        wr(QSSWD_REG_IRQ_EN, 32'h10, QSSWD_RESP_OKAY);
        pins(6'h00, 6'h20);
        manual_reset_in_n <= watchdog_fault_out_n;
        cyc(8);
        pins(6'h10, 6'h11);
        manual_reset_in_n <= 1'b1;
        $display("test watchdog done");
        summarize();
    end

    initial begin
        cyc(10000);
        n_fail++;
        summarize();
    end
endmodule
